/* logic/motor_driver_fault_supervisor.sv */
// fault supervisor of a dual h-bridge driver with an axi4-lite register slave
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module motor_driver_fault_supervisor #(
  parameter int LOGIC_UV_CYCLES = fault_sup_pkg::LOGIC_UV_CYC,
  parameter int RETRY_CYCLES = fault_sup_pkg::RETRY_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire fault_sup_pkg::pin_in_t PIN_IN,
  input wire logic INIT_FAULT_INDICATOR_PIN,
  input wire logic RESTART_FAULT_INDICATOR_PIN,
  output fault_sup_pkg::drive_out_t DRIVE,
  output logic [1:0] FAULT_INDICATOR_PIN_N,
  output logic LOGIC_RESET,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import fault_sup_pkg::*;

  localparam int PIN_W = $bits(pin_in_t);

  pin_in_t sync1_q, sync2_q, sync3_q, pin_q;
  logic bat_uv_q, logic_uv_q, por_q, luv_flag_q, thermal_q;
  logic [CNT_W-1:0] bat_cnt_q, luv_cnt_q, por_cnt_q;
  logic [1:0] en_prev_q, enb_prev_q;
  logic [1:0] clr_pulse, fault_release;
  logic [31:0] cfg_q [2];
  logic [2:0] ctl_pulse_q;
  logic [7:0] oc_flag_q;
  logic [3:0] off_hb_q;
  logic [1:0] fault_oc_q;
  logic [1:0] trip;
  oc_state_t state_q [2];
  logic fault_indicator_pin, flush, thermal_eff, supply_ok, all_off;

  // first set bit of a four-detector group, lowest index wins
  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[0]) begin
      r = 2'h0;
    end else if (v[1]) begin
      r = 2'h1;
    end else if (v[2]) begin
      r = 2'h2;
    end else if (v[3]) begin
      r = 2'h3;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: three stages, a change counts once stages two and three agree
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      pin_q <= '0;
    end else begin
      sync1_q <= PIN_IN;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < PIN_W; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pin_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // filtered supply reset forces the filters, fault flags, over-current state and configuration registers back to reset values
  assign flush = por_q;
  assign fault_indicator_pin = INIT_FAULT_INDICATOR_PIN | RESTART_FAULT_INDICATOR_PIN;

  ////////////////////////////////////////////////////////////////////////////
  // logic supply reset-level filter, counted on the logic clock
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      por_cnt_q <= '0;
      por_q <= 1'b0;
    end else if (!pin_q.logic_por) begin
      por_cnt_q <= '0;
      por_q <= 1'b0;
    end else if (por_cnt_q >= CNT_W'(POR_CYC - 1)) begin
      por_q <= 1'b1;
    end else begin
      por_cnt_q <= por_cnt_q + CNT_W'(1);
    end
  end

  // battery under-voltage filter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bat_cnt_q <= '0;
      bat_uv_q <= 1'b0;
    end else if (flush || !pin_q.bat_uv) begin
      bat_cnt_q <= '0;
      bat_uv_q <= 1'b0;
    end else if (bat_cnt_q >= CNT_W'(BAT_UV_CYC - 1)) begin
      bat_uv_q <= 1'b1;
    end else begin
      bat_cnt_q <= bat_cnt_q + CNT_W'(1);
    end
  end

  // logic supply under-voltage filter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      luv_cnt_q <= '0;
      logic_uv_q <= 1'b0;
    end else if (flush || !pin_q.logic_uv) begin
      luv_cnt_q <= '0;
      logic_uv_q <= 1'b0;
    end else if (luv_cnt_q >= CNT_W'(LOGIC_UV_CYCLES - 1)) begin
      logic_uv_q <= 1'b1;
    end else begin
      luv_cnt_q <= luv_cnt_q + CNT_W'(1);
    end
  end

  // sticky logic-supply abnormality flag, a new event wins over the clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      luv_flag_q <= 1'b0;
    end else if (flush) begin
      luv_flag_q <= 1'b0;
    end else if (logic_uv_q) begin
      luv_flag_q <= 1'b1;
    end else if (ctl_pulse_q[CTL_CLR_LUV_BIT]) begin
      luv_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal detection, held while battery is low
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      thermal_q <= 1'b0;
    end else if (flush) begin
      thermal_q <= 1'b0;
    end else if (!bat_uv_q) begin
      thermal_q <= pin_q.thermal;
    end
  end

  assign thermal_eff = thermal_q & ~INIT_FAULT_INDICATOR_PIN;
  // battery low gates the drivers and holds thermal detection; other counters and registers keep running
  assign supply_ok = ~bat_uv_q & ~logic_uv_q;
  // a full-bridge over-current trip on either channel stops both bridge pairs
  assign all_off = (&off_hb_q[1:0]) | (&off_hb_q[3:2]);

  ////////////////////////////////////////////////////////////////////////////
  // enable edge detection: clear pulses and fault pin release
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_prev_q <= '0;
      enb_prev_q <= '0;
    end else begin
      en_prev_q <= pin_q.enable;
      enb_prev_q <= pin_q.inverted_enable_input;
    end
  end

  assign clr_pulse = (en_prev_q & ~pin_q.enable)
                   | (~enb_prev_q & pin_q.inverted_enable_input)
                   | ctl_pulse_q[1:0];
  assign fault_release = (~en_prev_q & pin_q.enable)
                       | (enb_prev_q & ~pin_q.inverted_enable_input)
                       | ctl_pulse_q[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // per-channel over-current supervision
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic [3:0] det;
      logic [1:0] idx_q;
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] blank_cyc;
      logic half, retry;

      assign det = pin_q.oc[c*4 +: 4] & {4{~fault_indicator_pin}};
      assign half = cfg_q[c][CFG_HALF_BIT];
      assign retry = cfg_q[c][CFG_RETRY_BIT] & ~half;
      assign blank_cyc = cfg_q[c][CFG_SCBLANK_BIT] ? CNT_W'(SC_BLANK_CYC)
                                                   : CNT_W'(GEN_BLANK_CYC);
      assign trip[c] = (state_q[c] == OC_BLANKING) && det[idx_q]
                       && (cnt_q >= blank_cyc - CNT_W'(1));

      // state machine: blank, trip, then latch or retry
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          state_q[c] <= OC_NORMAL;
          cnt_q <= '0;
          idx_q <= 2'h0;
          off_hb_q[c*2 +: 2] <= 2'h0;
        end else if (flush) begin
          state_q[c] <= OC_NORMAL;
          cnt_q <= '0;
          idx_q <= 2'h0;
          off_hb_q[c*2 +: 2] <= 2'h0;
        end else if (clr_pulse[c] && (state_q[c] == OC_OFF_LATCH
                                      || state_q[c] == OC_OFF_RETRY)) begin
          state_q[c] <= OC_NORMAL;
          cnt_q <= '0;
          off_hb_q[c*2 +: 2] <= 2'h0;
        end else begin
          case (state_q[c])
            OC_NORMAL: begin
              if (|det) begin
                idx_q <= first_set(det);
                cnt_q <= '0;
                state_q[c] <= OC_BLANKING;
              end
            end
            OC_BLANKING: begin
              if (!det[idx_q]) begin
                state_q[c] <= OC_NORMAL;
              end else if (trip[c]) begin
                cnt_q <= '0;
                if (half) begin
                  off_hb_q[c*2 +: 2] <= idx_q[1] ? 2'b10 : 2'b01;
                end else begin
                  off_hb_q[c*2 +: 2] <= 2'b11;
                end
                state_q[c] <= retry ? OC_OFF_RETRY : OC_OFF_LATCH;
              end else begin
                cnt_q <= cnt_q + CNT_W'(1);
              end
            end
            OC_OFF_RETRY: begin
              if (cnt_q >= CNT_W'(RETRY_CYCLES - 1)) begin
                cnt_q <= '0;
                off_hb_q[c*2 +: 2] <= 2'h0;
                state_q[c] <= OC_NORMAL;
              end else begin
                cnt_q <= cnt_q + CNT_W'(1);
              end
            end
            default: begin
              state_q[c] <= OC_OFF_LATCH;
            end
          endcase
        end
      end

      // sticky detector flag of each trip, set wins over clear
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          oc_flag_q[c*4 +: 4] <= 4'h0;
        end else if (flush) begin
          oc_flag_q[c*4 +: 4] <= 4'h0;
        end else if (trip[c]) begin
          oc_flag_q[c*4 +: 4] <= oc_flag_q[c*4 +: 4] | (4'h1 << idx_q);
        end else if (clr_pulse[c]) begin
          oc_flag_q[c*4 +: 4] <= 4'h0;
        end
      end

      // latched fault pin cause
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          fault_oc_q[c] <= 1'b0;
        end else if (flush) begin
          fault_oc_q[c] <= 1'b0;
        end else if (trip[c]) begin
          fault_oc_q[c] <= 1'b1;
        end else if (fault_release[c]) begin
          fault_oc_q[c] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registered driver outputs and fault pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DRIVE <= '0;
      FAULT_INDICATOR_PIN_N <= 2'b11;
      LOGIC_RESET <= 1'b0;
    end else begin
      LOGIC_RESET <= por_q;
      for (int h = 0; h < 4; h++) begin
        // enables high and inverted enables low drive; anything else stops the output
        DRIVE.drive_en[h] <= supply_ok && !thermal_eff && !flush && !off_hb_q[h] && !all_off
                             && pin_q.enable[h/2] && !pin_q.inverted_enable_input[h/2];
        DRIVE.pwm[h] <= pin_q.pwm[h] && !thermal_eff;
      end
      for (int k = 0; k < 2; k++) begin
        FAULT_INDICATOR_PIN_N[k] <= !(thermal_eff || fault_oc_q[k]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;

  assign S_AXI_AWREADY = ~aw_have_q & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_have_q & ~S_AXI_BVALID;
  assign wr_go = aw_have_q & w_have_q & ~S_AXI_BVALID;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (aw_addr_q == CFG_CH0_OFS || aw_addr_q == CFG_CH1_OFS
            || aw_addr_q == CONTROL_OFS || aw_addr_q == STATUS_OFS) begin
          S_AXI_BRESP <= RESP_OKAY;
        end else begin
          S_AXI_BRESP <= RESP_SLVERR;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // configuration registers with byte lanes; control pulses last one cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_q[0] <= CFG_RST;
      cfg_q[1] <= CFG_RST;
      ctl_pulse_q <= '0;
    end else begin
      ctl_pulse_q <= '0;
      if (flush) begin
        cfg_q[0] <= CFG_RST;
        cfg_q[1] <= CFG_RST;
      end else if (wr_go) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_q[b] && aw_addr_q == CFG_CH0_OFS) begin
            cfg_q[0][b*8 +: 8] <= w_data_q[b*8 +: 8];
          end else if (w_strb_q[b] && aw_addr_q == CFG_CH1_OFS) begin
            cfg_q[1][b*8 +: 8] <= w_data_q[b*8 +: 8];
          end
        end
        if (aw_addr_q == CONTROL_OFS && w_strb_q[0]) begin
          ctl_pulse_q <= w_data_q[2:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel: data one cycle after the address is taken
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[ST_THERM_BIT] = thermal_eff;
    status[ST_BATUV_BIT] = bat_uv_q;
    status[ST_LUV_FLAG_BIT] = luv_flag_q;
    status[ST_LUV_NOW_BIT] = logic_uv_q;
    status[ST_OC_LSB +: 8] = oc_flag_q;
    status[ST_STATE_LSB +: 2] = state_q[0];
    status[ST_STATE_LSB + 2 +: 2] = state_q[1];
  end

  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= RESP_OKAY;
      if (S_AXI_ARADDR == CFG_CH0_OFS) begin
        S_AXI_RDATA <= cfg_q[0];
      end else if (S_AXI_ARADDR == CFG_CH1_OFS) begin
        S_AXI_RDATA <= cfg_q[1];
      end else if (S_AXI_ARADDR == STATUS_OFS) begin
        S_AXI_RDATA <= status;
      end else if (S_AXI_ARADDR == CONTROL_OFS) begin
        S_AXI_RDATA <= '0;
      end else begin
        S_AXI_RDATA <= '0;
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* logic/fault_sup_pkg.sv */
// package: constants, register map and carrier types of the fault supervisor
package fault_sup_pkg;

  // clock
  localparam int CLK_NS = 20;
  localparam int CNT_W = 24;

  // filter, blanking and retry times in their own units, then cycle counts
  localparam int BAT_UV_NS = 10000;
  localparam int BAT_UV_CYC = (BAT_UV_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOGIC_UV_US = 2500;
  localparam int LOGIC_UV_CYC = (LOGIC_UV_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int POR_NS = 13000;
  localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int SC_BLANK_NS = 1000;
  localparam int SC_BLANK_CYC = (SC_BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int GEN_BLANK_NS = 3000;
  localparam int GEN_BLANK_CYC = (GEN_BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_MS = 300;
  localparam int RETRY_CYC = (RETRY_MS * 1000000 + CLK_NS - 1) / CLK_NS;

  // register byte offsets
  localparam logic [7:0] CFG_CH0_OFS = 8'h00;
  localparam logic [7:0] CFG_CH1_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] CONTROL_OFS = 8'h0C;

  // channel_analog_config fields and reset value
  localparam int CFG_RETRY_BIT = 11;
  localparam int CFG_HALF_BIT = 12;
  localparam int CFG_SCBLANK_BIT = 13;
  localparam logic [31:0] CFG_RST = 32'h0000_2000;

  // control register fields (write one to act)
  localparam int CTL_CLR_CH0_BIT = 0;
  localparam int CTL_CLR_CH1_BIT = 1;
  localparam int CTL_CLR_LUV_BIT = 2;

  // status register fields
  localparam int ST_THERM_BIT = 0;
  localparam int ST_BATUV_BIT = 1;
  localparam int ST_LUV_FLAG_BIT = 2;
  localparam int ST_LUV_NOW_BIT = 3;
  localparam int ST_OC_LSB = 4;
  localparam int ST_STATE_LSB = 12;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-channel over-current states
  typedef enum logic [1:0] {
    OC_NORMAL = 2'b00,
    OC_BLANKING = 2'b01,
    OC_OFF_LATCH = 2'b10,
    OC_OFF_RETRY = 2'b11
  } oc_state_t;

  // asynchronous pin inputs; oc[3:0] channel 0, oc[7:4] channel 1
  typedef struct packed {
    logic bat_uv;
    logic logic_uv;
    logic logic_por;
    logic thermal;
    logic [7:0] oc;
    logic [1:0] enable;
    logic [1:0] inverted_enable_input;
    logic [3:0] pwm;
  } pin_in_t;

  // half-bridge drive; [1:0] bridge_outputs_a, [3:2] bridge_outputs_b
  typedef struct packed {
    logic [3:0] drive_en;
    logic [3:0] pwm;
  } drive_out_t;

endpackage

/* verification/host_mcu.sv */
// host microcontroller model that drives the enable pins
`timescale 1ns/1ps
`default_nettype none
module host_mcu (
  input wire logic clk,
  output logic [1:0] en,
  output logic [1:0] en_n
);
  // power up with both channels held in their off state
  initial begin
    en = 2'h0;
    en_n = 2'h3;
  end
  // put channel c into run state
  task run(input int c);
    @(posedge clk);
    en[c] <= 1'b1;
    en_n[c] <= 1'b0;
  endtask
  // one clear pulse, long enough to pass the pin synchronisers
  task pulse(input int c, input bit inv);
    @(posedge clk);
    if (inv) en_n[c] <= 1'b1; else en[c] <= 1'b0;
    repeat (6) @(posedge clk);
    if (inv) en_n[c] <= 1'b0; else en[c] <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* verification/fault_sup_properties.sv */
// checker of the fault supervisor pin behaviour
`timescale 1ns/1ps
`default_nettype none
module fault_sup_properties #(
  parameter int LOGIC_UV_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire fault_sup_pkg::pin_in_t PIN_IN,
  input wire logic INIT_FAULT_INDICATOR_PIN,
  input wire logic RESTART_FAULT_INDICATOR_PIN,
  input wire fault_sup_pkg::drive_out_t DRIVE,
  input wire logic [1:0] FAULT_INDICATOR_PIN_N,
  input wire logic LOGIC_RESET
);
  import fault_sup_pkg::*;
  logic [15:0] bat_q, luv_q, por_q, oc_q;
  logic [3:0] oc_last_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // saturating counts of how long each condition has stood at the pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bat_q <= '0;
      luv_q <= '0;
      por_q <= '0;
      oc_q <= '0;
      oc_last_q <= '0;
    end else begin
      bat_q <= PIN_IN.bat_uv ? bat_q + 16'(bat_q != 16'hFFFF) : '0;
      luv_q <= PIN_IN.logic_uv ? luv_q + 16'(luv_q != 16'hFFFF) : '0;
      por_q <= PIN_IN.logic_por ? por_q + 16'(por_q != 16'hFFFF) : '0;
      // losing the detector under blanking restarts blanking, so restart the count on any pattern change
      oc_last_q <= PIN_IN.oc[3:0];
      oc_q <= (PIN_IN.oc[3:0] != 4'h0 && PIN_IN.oc[3:0] == oc_last_q && !INIT_FAULT_INDICATOR_PIN
        && !RESTART_FAULT_INDICATOR_PIN && !LOGIC_RESET) ? oc_q + 16'(oc_q != 16'hFFFF) : '0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence hot_s;
    (PIN_IN.thermal && !PIN_IN.bat_uv && !INIT_FAULT_INDICATOR_PIN && !LOGIC_RESET)[*8];
  endsequence
  bat_off_a: assert property (bat_q >= 16'(BAT_UV_CYC + 8) |-> DRIVE.drive_en == 4'h0)
    else $error("outputs on after battery under-voltage");
  luv_off_a: assert property (luv_q >= 16'(LOGIC_UV_CYCLES + 8) |-> DRIVE.drive_en == 4'h0)
    else $error("outputs on after logic under-voltage");
  por_reset_a: assert property (por_q >= 16'(POR_CYC + 8) |-> LOGIC_RESET)
    else $error("logic reset missing");
  reset_off_a: assert property (LOGIC_RESET |-> DRIVE.drive_en == 4'h0)
    else $error("outputs on during logic reset");
  therm_off_a: assert property (hot_s |=> DRIVE.drive_en == 4'h0 && FAULT_INDICATOR_PIN_N == 2'b00)
    else $error("thermal shutdown not applied");
  therm_pwm_a: assert property (hot_s |=> DRIVE.pwm == 4'h0)
    else $error("pwm passed during thermal shutdown");
  en_gate_a: assert property ((!PIN_IN.enable[0])[*8] |=> DRIVE.drive_en[1:0] == 2'b00)
    else $error("drive on with enable off");
  oc_trip_a: assert property (oc_q == 16'(SC_BLANK_CYC + 10) |-> !FAULT_INDICATOR_PIN_N[0])
    else $error("over-current not reported");
  fault_indicator_pin_mask_a: assert property (INIT_FAULT_INDICATOR_PIN[*8] ##1 (INIT_FAULT_INDICATOR_PIN && FAULT_INDICATOR_PIN_N[0])
    |=> FAULT_INDICATOR_PIN_N[0])
    else $error("fault raised during diagnosis");
  // main scenarios
  cover property (oc_q == 16'(SC_BLANK_CYC + 10));
  cover property (hot_s);
  cover property ($rose(LOGIC_RESET));
endmodule
bind motor_driver_fault_supervisor fault_sup_properties #(.LOGIC_UV_CYCLES(LOGIC_UV_CYCLES)) chk (
  .CLK(CLK), .RST_N(RST_N), .PIN_IN(PIN_IN), .INIT_FAULT_INDICATOR_PIN(INIT_FAULT_INDICATOR_PIN),
  .RESTART_FAULT_INDICATOR_PIN(RESTART_FAULT_INDICATOR_PIN), .DRIVE(DRIVE), .FAULT_INDICATOR_PIN_N(FAULT_INDICATOR_PIN_N),
  .LOGIC_RESET(LOGIC_RESET));
`default_nettype wire

/* verification/tb_motor_driver_fault_supervisor.sv */
// testbench of the fault supervisor: register tasks and pin scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_motor_driver_fault_supervisor;
  import fault_sup_pkg::*;
  localparam int RT = 40;
  logic clk, rst_n, idg, rdg, lrst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  pin_in_t pin, pin_w;
  drive_out_t drv;
  logic [1:0] fpn, en, en_n, bresp, rresp, rs;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, v;
  int err_total, cmp_count;
  assign pin_w = {pin[19:8], en, en_n, pin[3:0]};
  host_mcu host (.clk(clk), .en(en), .en_n(en_n));
  motor_driver_fault_supervisor #(.LOGIC_UV_CYCLES(20), .RETRY_CYCLES(RT)) dut (
    .CLK(clk), .RST_N(rst_n), .PIN_IN(pin_w), .INIT_FAULT_INDICATOR_PIN(idg), .RESTART_FAULT_INDICATOR_PIN(rdg),
    .DRIVE(drv), .FAULT_INDICATOR_PIN_N(fpn), .LOGIC_RESET(lrst),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));
  ////////////////////////////////////////////////////////////////////////////////
  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // wait n edges, then sample at the falling edge
  task st(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // set the pins and let them stand n cycles
  task pp(input pin_in_t p, input int n);
    @(posedge clk);
    pin <= p;
    st(n);
  endtask
  // axi write: address and data offered together, each released when taken
  task wr32(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    int n;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv && br;
      rs = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      n++;
    end while (!tb && n < 200);
    br <= 1'b0;
    if (!tb) begin
      err_total++;
      $display("wrong value at %0t: no write response", $time);
    end
  endtask
  // axi read into v, response into rs
  task rd32(input logic [7:0] a);
    bit ta, tr;
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv && rr;
      v = rd;
      rs = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      n++;
    end while (!tr && n < 200);
    rr <= 1'b0;
    if (!tr) begin
      err_total++;
      $display("wrong value at %0t: no read response", $time);
    end
  endtask
  // counts and verdict
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #1000000;
    err_total++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n, idg, rdg, awv, wv, br, arv, rr} = '0;
    {pin, awa, wd, ara} = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    chk({drv, fpn}, {8'h00, 2'b11});
    rst_n <= 1'b1;
    host.run(0);
    host.run(1);
    st(8);
    chk(drv.drive_en, 4'hF);
    rd32(CFG_CH1_OFS);
    chk(v, CFG_RST);
    rd32(8'h10);
    chk(rs, RESP_SLVERR);
    $display("test registers done");
    pp('{pwm:4'hA, default:'0}, 8);
    chk(drv.pwm, 4'hA);
    pp('{thermal:1'b1, pwm:4'hA, default:'0}, 8);
    chk({drv, fpn}, {8'h00, 2'b00});
    pp('{pwm:4'hA, default:'0}, 8);
    chk({drv, fpn}, {4'hF, 4'hA, 2'b11});
    @(posedge clk);
    idg <= 1'b1;
    pp('{thermal:1'b1, default:'0}, 10);
    chk(fpn, 2'b11);
    pp('0, 8);
    @(posedge clk);
    idg <= 1'b0;
    $display("test thermal done");
    pp('{bat_uv:1'b1, default:'0}, 400);
    chk(drv.drive_en, 4'hF);
    pp('{bat_uv:1'b1, default:'0}, 110);
    chk(drv.drive_en, 4'h0);
    pp('{bat_uv:1'b1, thermal:1'b1, default:'0}, 20);
    rd32(STATUS_OFS);
    chk(v[1:0], 2'b10);
    pp('{logic_uv:1'b1, default:'0}, 30);
    chk(drv.drive_en, 4'h0);
    pp('0, 10);
    rd32(STATUS_OFS);
    chk(v[3:2], 2'b01);
    wr32(CONTROL_OFS, 32'h4);
    chk(rs, RESP_OKAY);
    rd32(STATUS_OFS);
    chk(v[3:2], 2'b00);
    $display("test supply done");
    pp('{oc:8'h01, default:'0}, 30);
    chk({drv.drive_en, fpn}, {4'hF, 2'b11});
    pp('{oc:8'h02, default:'0}, 70);
    pp('{oc:8'h06, default:'0}, 20);
    chk({drv.drive_en, fpn[0]}, 0);
    rd32(STATUS_OFS);
    chk(v[13:4], {2'h2, 8'h02});
    pp('0, 60);
    chk(drv.drive_en, 4'h0);
    host.pulse(0, 0);
    st(8);
    chk({drv.drive_en, fpn}, {4'hF, 2'b11});
    $display("test latch done");
    wr32(CFG_CH0_OFS, 32'h2800);
    pp('{oc:8'h08, default:'0}, 60);
    rd32(STATUS_OFS);
    chk(v[13:12], 2'h3);
    pp('0, RT + 10);
    chk(drv.drive_en, 4'hF);
    host.pulse(0, 1);
    st(8);
    chk(fpn, 2'b11);
    wr32(CFG_CH0_OFS, 32'h3800);
    pp('{oc:8'h01, default:'0}, 70);
    chk(drv.drive_en, 4'hE);
    rd32(STATUS_OFS);
    chk(v[13:12], 2'h2);
    wr32(CONTROL_OFS, 32'h1);
    st(2);
    chk({drv.drive_en, fpn}, {4'hF, 2'b11});
    pp('0, 8);
    host.pulse(0, 0);
    $display("test retry done");
    wr32(CFG_CH1_OFS, 32'h0);
    pp('{oc:8'h10, default:'0}, 100);
    chk(fpn[1], 1'b1);
    st(70);
    chk(fpn[1], 1'b0);
    pp('0, 8);
    host.pulse(1, 0);
    rdg <= 1'b1;
    pp('{oc:8'h01, default:'0}, 80);
    chk(fpn, 2'b11);
    pp('0, 8);
    @(posedge clk);
    rdg <= 1'b0;
    pp('{logic_por:1'b1, default:'0}, 700);
    chk({lrst, drv.drive_en}, 5'h10);
    pp('0, 10);
    rd32(CFG_CH0_OFS);
    chk(v, CFG_RST);
    $display("test faults done");
    print_verdict;
  end
endmodule
`default_nettype wire
